// file: rtl/pwm_output_override_correction.sv
// Output override, deadtime sampling and top/bottom correction stage of a six-channel PWM.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - Override enable drives output from level bit.
// - Buffered enable applies at commutation start.
// - Unbuffered set immediate, clear at cycle.
// - Level read gives bit or output.
// - Buffered level bits apply at commutation.
// - Odd complementary channel follows even complement.
// - Sample register read-only, holds sense inputs.
// - Method field selects none, manual, deadtime.
// - Method 11 samples mid or end cycle.
// - Method field unbuffered, applies at once.
// - Pair select picks even or odd value.
// - Pair select buffered to next cycle.
// - Deadtime capture only while both outputs off.
// - Cycle sampling senses at any duty.
// - No correction frees sense inputs as GPIO.
// - Even top, odd bottom; low positive current.
module pwm_output_override_correction (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pwm_ovr_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Generator side.
    input wire logic [pwm_ovr_pkg::NUM_CH-1:0] pwm_gen_i,
    input wire logic complementary_i,
    input wire logic center_aligned_i,
    input wire logic commutation_buffer_enable_i,
    input wire logic commutation_start_i,
    input wire logic cycle_start_i,
    input wire logic half_cycle_i,
    input wire logic deadtime_end_i,
    // Active-low current-sense pins, one per pair.
    input wire logic [pwm_ovr_pkg::NUM_PAIRS-1:0] current_sense_input_n_i,
    // Outputs.
    output logic [pwm_ovr_pkg::NUM_CH-1:0] pwm_o,
    output logic [pwm_ovr_pkg::NUM_PAIRS-1:0] value_odd_select_o,
    output logic [pwm_ovr_pkg::NUM_PAIRS-1:0] sense_gpio_o,
    output logic [1:0] correction_method_o
);
    import pwm_ovr_pkg::*;

    logic [NUM_CH-1:0] ovr_en_buf;
    logic [NUM_CH-1:0] ovr_en_act;
    logic [NUM_CH-1:0] level_buf;
    logic [NUM_CH-1:0] level_act;
    logic [NUM_PAIRS-1:0] pair_sel_buf;
    logic [NUM_PAIRS-1:0] pair_sel_act;
    logic [1:0] method;
    logic [NUM_CH-1:0] deadtime_sense_sample;
    logic [NUM_PAIRS-1:0] even_level;
    logic [NUM_PAIRS-1:0] sense_sync;
    logic [NUM_CH-1:0] next_pwm;
    logic [NUM_PAIRS-1:0] next_value_sel;
    logic [31:0] next_rdata;
    logic bus_req;
    logic wr_en;
    logic wr_level;
    logic wr_corr;

    // Sense pins are asynchronous and pass two flops before any use.
    pwm_sense_sync #(
        .WIDTH(NUM_PAIRS)
    ) u_sense_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(current_sense_input_n_i),
        .sync_o(sense_sync)
    );

    // A request is taken in the cycle that strobe stands while ack is low; ack follows a cycle later and lasts one cycle.
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SW_OUTPUT_ENABLE_OFS);
    assign wr_level = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SW_OUTPUT_LEVEL_OFS);
    assign wr_corr = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CORRECTION_CONTROL_OFS);

    // Written override enables sit in a buffer that reads back to software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovr_en_buf <= CH_RESET;
        end else if (wr_en) begin
            ovr_en_buf <= wb_dat_i[NUM_CH-1:0];
        end
    end

    // Active enables: commutation start when buffered, else set now and clear at cycle start.
    // A write and a cycle start in the same cycle: written ones set; a written zero clears only if the buffered bit was already zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovr_en_act <= CH_RESET;
        end else if (commutation_buffer_enable_i) begin
            if (commutation_start_i) begin
                ovr_en_act <= ovr_en_buf;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_en && wb_dat_i[i]) begin
                    ovr_en_act[i] <= 1'b1;
                end else if (cycle_start_i && !ovr_en_buf[i]) begin
                    ovr_en_act[i] <= 1'b0;
                end
            end
        end
    end

    // Level bits apply at commutation start when buffered, else at once on a write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_buf <= CH_RESET;
            level_act <= CH_RESET;
        end else begin
            if (wr_level) begin
                level_buf <= wb_dat_i[NUM_CH-1:0];
            end
            if (!commutation_buffer_enable_i) begin
                level_act <= wr_level ? wb_dat_i[NUM_CH-1:0] : level_buf;
            end else if (commutation_start_i) begin
                level_act <= level_buf;
            end
        end
    end

    // Method is unbuffered; pair selects are buffered to the next cycle start.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            method <= CORR_NONE;
            pair_sel_buf <= PAIR_RESET;
            pair_sel_act <= PAIR_RESET;
        end else begin
            if (wr_corr) begin
                method <= wb_dat_i[METHOD_MSB:METHOD_LSB];
                pair_sel_buf <= wb_dat_i[PAIR_SEL_MSB:PAIR_SEL_LSB];
            end
            if (cycle_start_i) begin
                pair_sel_act <= wr_corr ? wb_dat_i[PAIR_SEL_MSB:PAIR_SEL_LSB]
                                        : pair_sel_buf;
            end
        end
    end

    // Sense capture per pair. Both bits of a pair hold the same sampled pin.
    // Deadtime capture needs both outputs low, so no capture happens at 0 or 100 percent duty.
    generate
        for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_sample
            logic take;
            always_comb begin
                case (corr_method_e'(method))
                    CORR_DEADTIME: take = deadtime_end_i && !pwm_gen_i[2*p]
                                          && !pwm_gen_i[2*p+1];
                    CORR_CYCLE: take = center_aligned_i ? half_cycle_i
                                                        : cycle_start_i;
                    default: take = deadtime_end_i && !pwm_gen_i[2*p]
                                    && !pwm_gen_i[2*p+1];
                endcase
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    deadtime_sense_sample[2*p+1:2*p] <= '0;
                end else if (take) begin
                    deadtime_sense_sample[2*p+1:2*p] <= {2{sense_sync[p]}};
                end
            end
        end
    endgenerate

    // Output mux: override per channel; an overridden odd channel in complementary mode is its level bit ANDed with the inverse of the even output.
    always_comb begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
            even_level[p] = ovr_en_act[2*p] ? level_act[2*p] : pwm_gen_i[2*p];
            next_pwm[2*p] = even_level[p];
            if (!ovr_en_act[2*p+1]) begin
                next_pwm[2*p+1] = pwm_gen_i[2*p+1];
            end else if (complementary_i) begin
                next_pwm[2*p+1] = level_act[2*p+1] && !even_level[p];
            end else begin
                next_pwm[2*p+1] = level_act[2*p+1];
            end
        end
    end

    // Value register choice: manual uses pair selects; sensed methods use captured polarity.
    // A low sense bit (positive current) picks the even register.
    always_comb begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
            case (corr_method_e'(method))
                CORR_MANUAL: next_value_sel[p] = complementary_i && pair_sel_act[p];
                CORR_DEADTIME: next_value_sel[p] = complementary_i
                                                   && deadtime_sense_sample[2*p];
                CORR_CYCLE: next_value_sel[p] = complementary_i
                                                && deadtime_sense_sample[2*p];
                default: next_value_sel[p] = 1'b0;
            endcase
        end
    end

    // Output flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= CH_RESET;
            value_odd_select_o <= PAIR_RESET;
            sense_gpio_o <= PAIR_RESET;
            correction_method_o <= CORR_NONE;
        end else begin
            pwm_o <= next_pwm;
            value_odd_select_o <= next_value_sel;
            correction_method_o <= method;
            // Without correction the pins serve as general inputs.
            sense_gpio_o <= (method == CORR_NONE) ? sense_sync : PAIR_RESET;
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        next_rdata = '0;
        case (wb_adr_i)
            SW_OUTPUT_ENABLE_OFS: next_rdata[NUM_CH-1:0] = ovr_en_buf;
            SW_OUTPUT_LEVEL_OFS: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    next_rdata[i] = ovr_en_buf[i] ? level_buf[i] : pwm_o[i];
                end
            end
            DEADTIME_SAMPLE_STATUS_OFS: next_rdata[NUM_CH-1:0] = deadtime_sense_sample;
            CORRECTION_CONTROL_OFS: begin
                next_rdata[METHOD_MSB:METHOD_LSB] = method;
                next_rdata[PAIR_SEL_MSB:PAIR_SEL_LSB] = pair_sel_buf;
            end
            default: next_rdata = '0;
        endcase
    end

    // Bus answer one cycle after the request; writes to read-only space are dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rdata : '0;
        end
    end

    // Assertions on override enables and level bits.
    a_override_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ovr_en_act[0] |=> pwm_o[0] == $past(level_act[0]))
        else $error("overridden channel 0 does not follow its level bit");
    a_buffered_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        commutation_buffer_enable_i && !commutation_start_i |=> $stable(ovr_en_act))
        else $error("buffered enable changed outside commutation start");
    a_buffered_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        commutation_buffer_enable_i && commutation_start_i
        |=> ovr_en_act == $past(ovr_en_buf))
        else $error("buffered enable not applied at commutation start");
    a_set_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
        !commutation_buffer_enable_i && wr_en && wb_dat_i[0] |=> ovr_en_act[0])
        else $error("unbuffered enable set did not apply at once");
    a_clear_waits: assert property (@(posedge clk_i) disable iff (rst_i)
        !commutation_buffer_enable_i && !cycle_start_i && !wr_en && ovr_en_act[0]
        |=> ovr_en_act[0])
        else $error("enable released before cycle start");
    a_clear_at_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        !commutation_buffer_enable_i && cycle_start_i && !wr_en && !ovr_en_buf[0]
        |=> !ovr_en_act[0])
        else $error("enable not released at cycle start");
    a_level_held: assert property (@(posedge clk_i) disable iff (rst_i)
        commutation_buffer_enable_i && !commutation_start_i |=> $stable(level_act))
        else $error("buffered level changed outside commutation start");
    // Read-back of the level register depends on the buffered enable.
    a_level_read: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_we_i && wb_adr_i == SW_OUTPUT_LEVEL_OFS && !ovr_en_buf[1]
        |=> wb_dat_o[1] == $past(pwm_o[1]))
        else $error("level read does not show output state");
    a_level_read_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_we_i && wb_adr_i == SW_OUTPUT_LEVEL_OFS && ovr_en_buf[1]
        |=> wb_dat_o[1] == $past(level_buf[1]))
        else $error("level read does not show the stored bit");
    // An overridden odd channel must never be on together with its even partner when complementary; independent, it follows its level bit.
    a_comp_odd: assert property (@(posedge clk_i) disable iff (rst_i)
        complementary_i && ovr_en_act[1] && !level_act[1] |=> !pwm_o[1])
        else $error("odd channel active with level zero");
    a_comp_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
        complementary_i && ovr_en_act[1] && level_act[1] |=> pwm_o[1] == !pwm_o[0])
        else $error("odd channel is not the complement of its partner");
    a_indep_odd: assert property (@(posedge clk_i) disable iff (rst_i)
        !complementary_i && ovr_en_act[1] |=> pwm_o[1] == $past(level_act[1]))
        else $error("independent odd channel does not follow its level bit");
    // Sense capture and the value register choice.
    a_sample_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && wb_we_i && wb_adr_i == DEADTIME_SAMPLE_STATUS_OFS && !deadtime_end_i
        && !half_cycle_i && !cycle_start_i |=> $stable(deadtime_sense_sample))
        else $error("sample register changed by a write");
    a_deadtime_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_DEADTIME && (pwm_gen_i[0] || pwm_gen_i[1])
        |=> deadtime_sense_sample[1:0] == $past(deadtime_sense_sample[1:0]))
        else $error("deadtime sample captured while an output was on");
    a_half_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_CYCLE && center_aligned_i && !half_cycle_i
        |=> $stable(deadtime_sense_sample))
        else $error("sample taken outside the half cycle");
    a_cycle_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_CYCLE && !center_aligned_i && cycle_start_i
        |=> deadtime_sense_sample[0] == $past(sense_sync[0])
        && deadtime_sense_sample[1] == $past(sense_sync[0]))
        else $error("cycle end sample missed");
    a_sense_select: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_DEADTIME && complementary_i
        |=> value_odd_select_o[0] == $past(deadtime_sense_sample[0]))
        else $error("sensed polarity does not pick the value register");
    // Correction control: method at once, pair selects at the cycle start.
    a_method_now: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_corr |=> method == $past(wb_dat_i[METHOD_MSB:METHOD_LSB]))
        else $error("method write not applied at once");
    a_pair_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !cycle_start_i |=> $stable(pair_sel_act))
        else $error("pair select changed outside cycle start");
    a_pair_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        cycle_start_i && !wr_corr |=> pair_sel_act == $past(pair_sel_buf))
        else $error("pair select not applied at cycle start");
    a_manual_select: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_MANUAL && complementary_i
        |=> value_odd_select_o == $past(pair_sel_act))
        else $error("manual correction does not follow the pair selects");
    a_no_corr: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_NONE |=> value_odd_select_o == PAIR_RESET)
        else $error("value select active without correction");
    a_gpio_free: assert property (@(posedge clk_i) disable iff (rst_i)
        method == CORR_NONE |=> sense_gpio_o == $past(sense_sync))
        else $error("sense pins not passed on as general inputs");
    a_gpio_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
        method != CORR_NONE |=> sense_gpio_o == PAIR_RESET)
        else $error("sense pins passed on while correction is active");
    // Reset state and the bus handshake.
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> ovr_en_act == CH_RESET && method == CORR_NONE
        && pair_sel_act == PAIR_RESET)
        else $error("reset left override or correction state");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule // pwm_output_override_correction

// file: rtl/pwm_ovr_pkg.sv
// Package with register map, field positions and encodings for the PWM output override block.
package pwm_ovr_pkg;
    localparam int NUM_CH = 6;
    localparam int NUM_PAIRS = 3;
    localparam int ADDR_W = 4;
    // Register byte offsets on the register bus.
    localparam logic [ADDR_W-1:0] SW_OUTPUT_ENABLE_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] SW_OUTPUT_LEVEL_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] DEADTIME_SAMPLE_STATUS_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] CORRECTION_CONTROL_OFS = 4'hc;
    // Field positions in the correction control register.
    localparam int METHOD_LSB = 4;
    localparam int METHOD_MSB = 5;
    localparam int PAIR_SEL_LSB = 0;
    localparam int PAIR_SEL_MSB = 2;
    // Correction method encodings.
    typedef enum logic [1:0] {
        CORR_NONE = 2'h0,
        CORR_MANUAL = 2'h1,
        CORR_DEADTIME = 2'h2,
        CORR_CYCLE = 2'h3
    } corr_method_e;
    // Reset values.
    localparam logic [NUM_CH-1:0] CH_RESET = 6'h00;
    localparam logic [NUM_PAIRS-1:0] PAIR_RESET = 3'h0;
endpackage

// file: rtl/pwm_sense_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module pwm_sense_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage to settle metastability.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pwm_sense_sync

// file: tb/power_stage_model.sv
// Behavioural power stage that reports phase current direction on its sense pins.
`timescale 1ns/1ps
module power_stage_model (
    input wire logic [2:0] cur_neg_i,
    output logic [2:0] sense_n_o
);
    // Pins are active low: low for positive current, high for negative current.
    assign sense_n_o = cur_neg_i;
endmodule // power_stage_model

// file: tb/tb.sv
// Self-checking bench for the PWM output override and correction stage.
`timescale 1ns/1ps
module tb;
    import pwm_ovr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack;
    logic comp = 1'b0;
    logic center = 1'b0;
    logic cbuf = 1'b0;
    logic [3:0] ev = '0; // Commutation, cycle start, half cycle, deadtime end.
    logic [5:0] gen = '0;
    logic [5:0] pwm;
    logic [2:0] cur_neg = '0;
    logic [2:0] sense_n;
    logic [2:0] odd_sel;
    logic [2:0] gpio;
    logic [1:0] meth;
    int errors = 0;
    int n_checks = 0;
    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;
    pwm_output_override_correction dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_gen_i(gen), .complementary_i(comp),
        .center_aligned_i(center), .commutation_buffer_enable_i(cbuf),
        .commutation_start_i(ev[0]), .cycle_start_i(ev[1]), .half_cycle_i(ev[2]),
        .deadtime_end_i(ev[3]), .current_sense_input_n_i(sense_n), .pwm_o(pwm),
        .value_odd_select_o(odd_sel), .sense_gpio_o(gpio), .correction_method_o(meth));
    power_stage_model stage_u (.cur_neg_i(cur_neg), .sense_n_o(sense_n));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hf);
    endtask
    task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(name, rd, {24'h0, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One-cycle event pulse, then room for the registered outputs to follow.
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev <= 4'h0;
        idle(3);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hang counts as a failure; the tests need well under a thousand cycles.
    initial begin
        idle(5000);
        errors++;
        results();
    end
    initial begin
        idle(2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("enable", SW_OUTPUT_ENABLE_OFS, 8'h00);
        rdc("level", SW_OUTPUT_LEVEL_OFS, 8'h00);
        rdc("ctrl", CORRECTION_CONTROL_OFS, 8'h00);
        // Independent override hides the generator pattern.
        gen <= 6'h0c;
        wr(SW_OUTPUT_LEVEL_OFS, 8'h15);
        rdc("level gen", SW_OUTPUT_LEVEL_OFS, 8'h0c);
        wr(SW_OUTPUT_ENABLE_OFS, 8'h3f);
        idle(2);
        chk("pwm indep", pwm, 6'h15);
        rdc("level ovr", SW_OUTPUT_LEVEL_OFS, 8'h15);
        // Complementary odd channels follow the inverse of their even partner.
        comp <= 1'b1;
        wr(SW_OUTPUT_LEVEL_OFS, 8'h3f);
        idle(2);
        chk("pwm comp on", pwm, 6'h15);
        wr(SW_OUTPUT_LEVEL_OFS, 8'h2a);
        idle(2);
        chk("pwm comp off", pwm, 6'h2a);
        // Unbuffered release waits for the cycle start.
        wr(SW_OUTPUT_ENABLE_OFS, 8'h00);
        idle(2);
        chk("pwm held", pwm, 6'h2a);
        pulse(1);
        chk("pwm released", pwm, 6'h0c);
        // Buffered enable and level wait for the commutation start.
        cbuf <= 1'b1;
        wr(SW_OUTPUT_LEVEL_OFS, 8'h15);
        wr(SW_OUTPUT_ENABLE_OFS, 8'h3f);
        rdc("enable buf", SW_OUTPUT_ENABLE_OFS, 8'h3f);
        idle(2);
        chk("pwm before comm", pwm, 6'h0c);
        pulse(0);
        chk("pwm after comm", pwm, 6'h15);
        wr(SW_OUTPUT_LEVEL_OFS, 8'h2a);
        idle(2);
        chk("pwm level held", pwm, 6'h15);
        rdc("level buf", SW_OUTPUT_LEVEL_OFS, 8'h2a);
        pulse(0);
        chk("pwm level comm", pwm, 6'h2a);
        // Refused writes: read-only sample register, low byte not selected; then an unmapped read.
        wr(DEADTIME_SAMPLE_STATUS_OFS, 8'h3f);
        rdc("sample ro", DEADTIME_SAMPLE_STATUS_OFS, 8'h00);
        bus(1'b1, CORRECTION_CONTROL_OFS, 32'h15, 4'he);
        rdc("ctrl sel", CORRECTION_CONTROL_OFS, 8'h00);
        rdc("unmapped", 4'h2, 8'h00);
        // Manual correction: pair selects wait for the cycle start.
        wr(CORRECTION_CONTROL_OFS, 8'h15);
        idle(1);
        chk("method manual", meth, 2'h1);
        chk("sel held", odd_sel, 3'h0);
        rdc("ctrl buf", CORRECTION_CONTROL_OFS, 8'h15);
        pulse(1);
        chk("sel applied", odd_sel, 3'h5);
        // Deadtime sampling with all generator outputs off.
        wr(CORRECTION_CONTROL_OFS, 8'h20);
        gen <= 6'h00;
        cur_neg <= 3'b011;
        idle(4);
        pulse(3);
        rdc("sample deadtime", DEADTIME_SAMPLE_STATUS_OFS, 8'h0f);
        pulse(1);
        chk("sel sensed", odd_sel, 3'h3);
        // A pair with an output on keeps its old sample.
        gen <= 6'h01;
        cur_neg <= 3'b100;
        idle(4);
        pulse(3);
        rdc("sample blocked", DEADTIME_SAMPLE_STATUS_OFS, 8'h33);
        // Cycle sampling at full duty: end of cycle when edge aligned.
        wr(CORRECTION_CONTROL_OFS, 8'h30);
        gen <= 6'h3f;
        cur_neg <= 3'b010;
        idle(4);
        pulse(1);
        rdc("sample edge", DEADTIME_SAMPLE_STATUS_OFS, 8'h0c);
        // Center aligned samples at the half cycle only.
        center <= 1'b1;
        cur_neg <= 3'b001;
        idle(4);
        pulse(1);
        rdc("sample no mid", DEADTIME_SAMPLE_STATUS_OFS, 8'h0c);
        pulse(2);
        rdc("sample mid", DEADTIME_SAMPLE_STATUS_OFS, 8'h03);
        chk("sel cycle", odd_sel, 3'h1);
        // No correction frees the sense pins.
        wr(CORRECTION_CONTROL_OFS, 8'h00);
        idle(2);
        chk("method none", meth, 2'h0);
        chk("gpio", gpio, 3'b001);
        // A reset in mid-run must drop the active overrides, not only the buffers.
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("enable rst", SW_OUTPUT_ENABLE_OFS, 8'h00);
        chk("pwm rst", pwm, 6'h3f);
        results();
    end
endmodule // tb
